/* core/sbce_pkg.sv */
package sbce_pkg;
   // Command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_STOP = 4'h6;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_ACT = 4'h3;
   // Burst length codes
   localparam logic [2:0] BL_1 = 3'h0;
   localparam logic [2:0] BL_2 = 3'h1;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned WR_RECOVERY_CYC = 2;
   localparam int unsigned MASK_LAT_CYC = 2;
   localparam int unsigned PRECHARGE_TIME_NS = 20;
   localparam int unsigned PRECHARGE_CYC =
      (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SR_EXIT_TIME_NS = 72;
   localparam int unsigned SR_EXIT_CYC =
      (SR_EXIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] COL_RESET = 10'h000;
endpackage : sbce_pkg

/* core/sbce_col_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Column generator: sequential wrap or interleaved xor within burst
module sbce_col_seq #(
   parameter int COL_W = 10
) (
   input wire logic [COL_W-1:0] start_col,
   input wire logic [COL_W-1:0] beat,
   input wire logic [2:0] bl_code,
   input wire logic interleave,
   output logic [COL_W-1:0] col
);
   initial begin
      if (COL_W < 4) $error("sbce_col_seq: COL_W too small");
   end
   wire [COL_W-1:0] low_mask;
   wire [COL_W-1:0] seq_sum;
   wire [COL_W-1:0] seq_col;
   wire [COL_W-1:0] ilv_col;
   assign low_mask = (bl_code == sbce_pkg::BL_2) ? COL_W'(1) :
                     (bl_code == sbce_pkg::BL_4) ? COL_W'(3) :
                     (bl_code == sbce_pkg::BL_8) ? COL_W'(7) :
                     (bl_code == sbce_pkg::BL_PAGE) ? {COL_W{1'b1}} : COL_W'(0);
   assign seq_sum = start_col + beat;
   // No carry out of the wrapped field
   assign seq_col = (start_col & ~low_mask) | (seq_sum & low_mask);
   assign ilv_col = start_col ^ (beat & low_mask);
   assign col = (interleave && bl_code != sbce_pkg::BL_PAGE) ? ilv_col : seq_col;
endmodule : sbce_col_seq
`default_nettype wire

/* core/sbce_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Read decoded from cs ras cas we
// - Burst type and length from mode
// - Write decoded, address gives start column
// - Write data same cycle, extra ignored
// - Read restarts read burst, old data drains
// - Write restarts write burst full length
// - Read ends write, residue discarded
// - Burst stop ends full page burst
// - Sequential wraps low bits, no carry
// - Interleaved inverts low start bits
// - Addr bit ten selects auto-precharge
// - Write precharge two clocks after last
// - Precharge one bank or all
// - Self refresh entry, inputs ignored
// - Self refresh exit on clock enable
// - Power down gates receivers, no refresh
// - Mask: read two later, write immediate
module sbce_top #(
   parameter int COL_W = 10,
   parameter int DATA_W = 16
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic clock_enable_input,
   input wire logic data_mask_input,
   input wire logic addr_bit_ten,
   input wire logic [1:0] bank_select_bits,
   input wire logic [COL_W-1:0] col_addr,
   input wire logic [DATA_W-1:0] dq_in,
   input wire logic [2:0] mode_burst_len,
   input wire logic mode_interleave,
   input wire logic [1:0] mode_cas_latency,
   input wire logic [3:0] bank_active_in,
   output logic [DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   output logic [1:0] read_bank,
   output logic [COL_W-1:0] read_col,
   output logic read_strobe,
   input wire logic [DATA_W-1:0] read_data,
   output logic write_strobe,
   output logic [1:0] write_bank,
   output logic [COL_W-1:0] write_col,
   output logic [DATA_W-1:0] write_data,
   output logic [3:0] precharge_banks,
   output logic self_refresh,
   output logic power_down,
   output logic burst_busy
);
   initial begin
      if (COL_W < 4 || DATA_W < 1) $error("sbce_top: bad width");
   end
   typedef enum logic [1:0] {SBCE_IDLE, SBCE_RD, SBCE_WR} sbce_burst_e;
   typedef enum logic [1:0] {SBCE_RUN, SBCE_SREF, SBCE_PDN} sbce_pwr_e;

   // Reset release and pin synchronisers
   logic rst_s1, rst_sync_n;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1 <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_sync_n <= rst_s1;
      end
   end
   localparam int PW = 9 + COL_W + DATA_W;
   logic [PW-1:0] pin_s1, pin_s2;
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         // Idle pins with clock enable high, so release does not fake a power down
         pin_s1 <= {{(PW-9){1'b0}}, 9'h1ff};
         pin_s2 <= {{(PW-9){1'b0}}, 9'h1ff};
      end else begin
         pin_s1 <= {dq_in, col_addr, bank_select_bits, addr_bit_ten, data_mask_input,
                    clock_enable_input, cs_n, ras_n, cas_n, we_n};
         pin_s2 <= pin_s1;
      end
   end
   wire [3:0] cmd = pin_s2[3:0];
   wire cke = pin_s2[4];
   wire dqm = pin_s2[5];
   wire a10 = pin_s2[6];
   wire [1:0] bsel = pin_s2[8:7];
   wire [COL_W-1:0] cadr = pin_s2[8+COL_W:9];
   wire [DATA_W-1:0] din = pin_s2[PW-1:9+COL_W];

   logic cke_reg;
   sbce_burst_e burst_reg, burst_next;
   sbce_pwr_e pwr_reg;
   logic [COL_W-1:0] start_reg, beat_reg, beat_next;
   logic [1:0] bank_reg;
   logic ap_reg;
   logic [1:0] wr_rec_reg;
   logic [3:0] pre_reg;
   logic [2:0] xsr_reg;
   logic [3:0] rd_pipe_reg;
   logic [2:0] dqm_pipe_reg;
   logic [DATA_W-1:0] dq_reg;
   logic [DATA_W-1:0] dq_d2_reg;
   logic [DATA_W-1:0] dq_d3_reg;

   // Commands only count while powered up and clocked
   wire awake = (pwr_reg == SBCE_RUN) && cke_reg && (xsr_reg == 3'h0);
   wire is_rd = awake && cmd == sbce_pkg::CMD_READ;
   wire is_wr = awake && cmd == sbce_pkg::CMD_WRITE;
   wire is_stop = awake && cmd == sbce_pkg::CMD_STOP && mode_burst_len == sbce_pkg::BL_PAGE;
   wire is_pre = awake && cmd == sbce_pkg::CMD_PRE;
   wire is_sref = awake && !cke && cmd == sbce_pkg::CMD_REF && bank_active_in == 4'h0;
   wire is_pdn = awake && !cke && !is_sref && burst_reg == SBCE_IDLE;
   wire new_burst = is_rd || is_wr;
   wire [COL_W-1:0] last_beat =
      (mode_burst_len == sbce_pkg::BL_2) ? COL_W'(1) :
      (mode_burst_len == sbce_pkg::BL_4) ? COL_W'(3) :
      (mode_burst_len == sbce_pkg::BL_8) ? COL_W'(7) :
      (mode_burst_len == sbce_pkg::BL_PAGE) ? {COL_W{1'b1}} : COL_W'(0);
   wire at_end = beat_reg == last_beat && mode_burst_len != sbce_pkg::BL_PAGE;
   wire [COL_W-1:0] cur_start = new_burst ? cadr : start_reg;
   wire [COL_W-1:0] cur_beat = new_burst ? COL_W'(0) : beat_reg;
   wire [COL_W-1:0] cur_col;
   sbce_col_seq #(.COL_W(COL_W)) u_col (
      .start_col(cur_start),
      .beat(cur_beat),
      .bl_code(mode_burst_len),
      .interleave(mode_interleave),
      .col(cur_col)
   );
   // New command overrides remaining addresses of either kind
   always_comb begin
      burst_next = burst_reg;
      beat_next = beat_reg + COL_W'(1);
      if (is_rd) begin
         burst_next = SBCE_RD;
         beat_next = COL_W'(1);
      end else if (is_wr) begin
         burst_next = SBCE_WR;
         beat_next = COL_W'(1);
      end else if (is_stop || (burst_reg != SBCE_IDLE && at_end)) begin
         burst_next = SBCE_IDLE;
      end
      if ((is_rd || is_wr) && mode_burst_len == sbce_pkg::BL_1) burst_next = SBCE_IDLE;
   end
   wire rd_beat = is_rd || (burst_reg == SBCE_RD && awake && !is_wr && !is_stop);
   wire wr_beat = is_wr || (burst_reg == SBCE_WR && awake && !is_rd && !is_stop);
   wire cur_ap = new_burst ? a10 : ap_reg;
   wire wr_last = wr_beat && (mode_burst_len == sbce_pkg::BL_1 ||
                  (!is_wr && at_end));
   wire rd_last = rd_beat && (mode_burst_len == sbce_pkg::BL_1 || (!is_rd && at_end));
   wire [COL_W-1:0] cl_lead = COL_W'(mode_cas_latency) - COL_W'(1);
   // Read auto-precharge starts cas latency minus one before the end
   wire rd_ap_go = cur_ap && rd_beat && (mode_burst_len == sbce_pkg::BL_1 ||
                   cur_beat == last_beat - cl_lead || rd_last);
   wire [3:0] bank_onehot = 4'h1 << bsel;
   wire [3:0] pre_cmd_banks = a10 ? 4'hf : bank_onehot;
   wire [3:0] ap_banks = 4'h1 << bank_reg;

   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         cke_reg <= 1'b1;
         burst_reg <= SBCE_IDLE;
         start_reg <= sbce_pkg::COL_RESET;
         beat_reg <= sbce_pkg::COL_RESET;
         bank_reg <= 2'h0;
         ap_reg <= 1'b0;
      end else begin
         cke_reg <= cke;
         burst_reg <= (is_sref || is_pdn) ? SBCE_IDLE : burst_next;
         beat_reg <= awake ? beat_next : beat_reg;
         if (new_burst) begin
            start_reg <= cadr;
            bank_reg <= bsel;
            ap_reg <= a10;
         end
      end
   end

   // Power state and self refresh exit wait
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pwr_reg <= SBCE_RUN;
         xsr_reg <= 3'h0;
      end else begin
         case (pwr_reg)
            SBCE_RUN: begin
               if (is_sref) pwr_reg <= SBCE_SREF;
               else if (is_pdn) pwr_reg <= SBCE_PDN;
               if (xsr_reg != 3'h0) xsr_reg <= xsr_reg - 3'h1;
            end
            SBCE_SREF: begin
               if (cke) begin
                  pwr_reg <= SBCE_RUN;
                  xsr_reg <= 3'(sbce_pkg::SR_EXIT_CYC);
               end
            end
            SBCE_PDN: if (cke) pwr_reg <= SBCE_RUN;
            default: pwr_reg <= SBCE_RUN;
         endcase
      end
   end

   // Write auto-precharge after recovery; precharge strobes
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wr_rec_reg <= 2'h0;
         pre_reg <= 4'h0;
      end else begin
         pre_reg <= 4'h0;
         if (wr_last && cur_ap) wr_rec_reg <= 2'(sbce_pkg::WR_RECOVERY_CYC);
         else if (wr_rec_reg != 2'h0) wr_rec_reg <= wr_rec_reg - 2'h1;
         // Pulse lands two cycles after the last write beat
         if (wr_rec_reg == 2'(sbce_pkg::WR_RECOVERY_CYC)) pre_reg <= ap_banks;
         if (rd_ap_go) pre_reg <= ap_banks | (new_burst ? bank_onehot : 4'h0);
         if (is_pre) pre_reg <= pre_cmd_banks;
      end
   end

   // Read data pipeline: cas latency, mask two later
   always_ff @(posedge core_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rd_pipe_reg <= 4'h0;
         dqm_pipe_reg <= 3'h0;
         dq_reg <= '0;
         dq_d2_reg <= '0;
         dq_d3_reg <= '0;
      end else begin
         rd_pipe_reg <= {rd_pipe_reg[2:0], rd_beat};
         dqm_pipe_reg <= {dqm_pipe_reg[1:0], dqm};
         dq_reg <= read_data;
         dq_d2_reg <= dq_reg;
         dq_d3_reg <= dq_d2_reg;
      end
   end
   wire [1:0] cl_idx = (mode_cas_latency == 2'h0) ? 2'h0 : mode_cas_latency - 2'h1;
   wire rd_valid = rd_pipe_reg[cl_idx];
   wire rd_masked = dqm_pipe_reg[sbce_pkg::MASK_LAT_CYC - 1];
   // Data delayed by the same cas latency as its valid flag
   assign dq_out = (cl_idx == 2'h0) ? dq_reg : (cl_idx == 2'h1) ? dq_d2_reg : dq_d3_reg;
   assign dq_oe_n = !(rd_valid && !rd_masked);

   assign read_strobe = rd_beat;
   assign read_bank = new_burst ? bsel : bank_reg;
   assign read_col = cur_col;
   assign write_strobe = wr_beat && !dqm;
   assign write_bank = new_burst ? bsel : bank_reg;
   assign write_col = cur_col;
   assign write_data = din;
   assign precharge_banks = pre_reg;
   assign self_refresh = pwr_reg == SBCE_SREF;
   assign power_down = pwr_reg == SBCE_PDN;
   assign burst_busy = burst_reg != SBCE_IDLE;

   stop_ends_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_stop && !new_burst |=> !burst_busy) else $error("burst stop ignored");
   rd_start_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_rd |-> read_strobe && read_col == cadr) else $error("read start column");
   wr_start_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_wr && !dqm |-> write_strobe && write_col == cadr) else $error("write start");
   rd_kills_wr_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_rd |-> !write_strobe) else $error("write after read");
   wr_mask_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      wr_beat && dqm |-> !write_strobe) else $error("masked write");
   rd_mask_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      dqm ##1 1'b1 |=> dq_oe_n) else $error("read mask latency");
   wr_ap_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      wr_last && cur_ap && !is_pre && !rd_ap_go |-> ##2 precharge_banks[bank_reg])
      else $error("write recovery");
   pre_all_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_pre && a10 |=> precharge_banks == 4'hf) else $error("precharge all");
   sref_hold_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      self_refresh && !cke |=> self_refresh && !read_strobe) else $error("sref exit");
   sref_exit_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      self_refresh && cke |=> !self_refresh ##0 !awake) else $error("exit wait");
   seq_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      rd_beat && !mode_interleave && mode_burst_len == sbce_pkg::BL_4
      |-> read_col[COL_W-1:2] == cur_start[COL_W-1:2]) else $error("seq carry");
   ilv_a: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
      rd_beat && mode_interleave && mode_burst_len == sbce_pkg::BL_8
      |-> read_col == (cur_start ^ (cur_beat & COL_W'(7)))) else $error("interleave");
   cv_rd_rd: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_rd ##1 is_rd);
   cv_wr_rd: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_wr ##1 is_rd);
   cv_sref: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      is_sref ##[1:20] (self_refresh && cke));
   cv_ap: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
      wr_last && cur_ap);
endmodule : sbce_top
`default_nettype wire

/* verification/sbce_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Controller stand-in: command pins, clock enable, mask and write words
module sbce_ctrl_model (
   input wire logic core_clk,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic clock_enable_input,
   output logic data_mask_input,
   output logic addr_bit_ten,
   output logic [1:0] bank_select_bits,
   output logic [9:0] col_addr,
   output logic [15:0] dq_in
);
   logic [15:0] cyc_reg = 16'h0000;
   logic [15:0] wr_cyc = 16'h0000;
   function automatic logic [15:0] word_at(input logic [15:0] c);
      return (c * 16'h9e37) ^ 16'h5a5a;
   endfunction : word_at
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'h8;
      clock_enable_input = 1'b1;
      data_mask_input = 1'b0;
      addr_bit_ten = 1'b0;
      bank_select_bits = 2'h0;
      col_addr = 10'h000;
      dq_in = 16'h0000;
   end
   // Data pins never hold a stale word, so late or early capture shows
   always @(posedge core_clk) begin
      cyc_reg <= cyc_reg + 16'h0001;
      dq_in <= word_at(cyc_reg);
   end
   task automatic cmd(input logic [3:0] code, input logic [9:0] col, input logic a10 = 1'b0,
                      input logic [1:0] bank = 2'h0, input logic cke = 1'b1,
                      input logic dqm = 1'b0);
      @(posedge core_clk);
      wr_cyc = cyc_reg;
      {cs_n, ras_n, cas_n, we_n} <= code;
      col_addr <= col;
      addr_bit_ten <= a10;
      bank_select_bits <= bank;
      clock_enable_input <= cke;
      data_mask_input <= dqm;
      @(posedge core_clk);
      {cs_n, ras_n, cas_n, we_n} <= 4'h7;
      col_addr <= ~col_addr;
   endtask : cmd
endmodule : sbce_ctrl_model
`default_nettype wire

/* verification/test_sdram_burst_command_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module test_sdram_burst_command_engine;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, ras_n, cas_n, we_n, clock_enable_input, data_mask_input, addr_bit_ten;
   logic dq_oe_n, read_strobe, write_strobe, self_refresh, power_down, burst_busy;
   logic [1:0] bank_select_bits, read_bank, write_bank;
   logic [1:0] mode_cas_latency = 2'h2;
   logic [2:0] mode_burst_len = 3'h2;
   logic mode_interleave = 1'b0;
   logic [3:0] bank_active_in = 4'hf;
   logic [3:0] precharge_banks;
   logic [3:0] pre_val = 4'h0;
   logic [9:0] col_addr, read_col, write_col;
   logic [15:0] dq_in, dq_out, read_data, write_data;
   logic [25:0] wr_q[$], ew_q[$];
   logic [9:0] rd_q[$], er_q[$];
   logic [16:0] hist[4];
   logic masked = 1'b0;
   logic [31:0] seed = 32'h0000ad6f;
   int err_count = 0, tests_run = 0, cyc = 0, last_w = 0, pre_cyc = 0;
   sbce_ctrl_model ctrl (.core_clk, .cs_n, .ras_n, .cas_n, .we_n, .clock_enable_input,
      .data_mask_input, .addr_bit_ten, .bank_select_bits, .col_addr, .dq_in);
   sbce_top #(.COL_W(10), .DATA_W(16)) dut (.core_clk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n,
      .clock_enable_input, .data_mask_input, .addr_bit_ten, .bank_select_bits, .col_addr,
      .dq_in, .mode_burst_len, .mode_interleave, .mode_cas_latency, .bank_active_in, .dq_out,
      .dq_oe_n, .read_bank, .read_col, .read_strobe, .read_data, .write_strobe, .write_bank,
      .write_col, .write_data, .precharge_banks, .self_refresh, .power_down, .burst_busy);
   // Array stand-in: word depends on bank and column so misaddressing shows
   assign read_data = {read_bank, 4'h0, read_col} ^ 16'h3c3c;
   initial forever #50 core_clk = ~core_clk;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic int blen();
      return mode_burst_len == sbce_pkg::BL_PAGE ? 1024 : 1 << mode_burst_len;
   endfunction : blen
   function automatic logic [9:0] col_at(input logic [9:0] s, input int n);
      logic [9:0] m;
      m = 10'(blen() - 1);
      if (mode_interleave && m != 10'h3ff) return (s & ~m) | ((s ^ 10'(n)) & m);
      return (s & ~m) | ((s + 10'(n)) & m);
   endfunction : col_at
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         complete_run();
      end
   end
   always @(negedge core_clk) begin
      if (write_strobe === 1'b1) begin
         wr_q.push_back({write_col, write_data});
         last_w = cyc;
      end
      if (read_strobe === 1'b1) rd_q.push_back(read_col);
      if (precharge_banks !== 4'h0) begin
         pre_cyc = cyc;
         pre_val = precharge_banks;
      end
      for (int i = 3; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = {read_strobe === 1'b1, read_data};
      if (hist[mode_cas_latency][16] === 1'b1 && !masked) begin
         `CHECK(dq_oe_n, 1'b0)
         `CHECK(dq_out, hist[mode_cas_latency][15:0])
      end else if (hist[mode_cas_latency][16] === 1'b1) `CHECK(dq_oe_n, 1'b1)
   end
   task automatic issue(input logic [3:0] c, input logic [9:0] s, input int n);
      ctrl.cmd(c, s);
      for (int i = 0; i < n; i++) begin
         if (c == sbce_pkg::CMD_WRITE)
            ew_q.push_back({col_at(s, i), ctrl.word_at(ctrl.wr_cyc + 16'(i))});
         if (c == sbce_pkg::CMD_READ) er_q.push_back(col_at(s, i));
      end
   endtask : issue
   task automatic settle();
      repeat (4) @(negedge core_clk);
      for (int k = 0; k < 1100 && burst_busy !== 1'b0; k++) @(negedge core_clk);
      repeat (6) @(negedge core_clk);
      `CHECK(wr_q.size(), ew_q.size())
      `CHECK(rd_q.size(), er_q.size())
      foreach (ew_q[i]) if (i < wr_q.size()) `CHECK(wr_q[i], ew_q[i])
      foreach (er_q[i]) if (i < rd_q.size()) `CHECK(rd_q[i], er_q[i])
      wr_q = {};
      ew_q = {};
      rd_q = {};
      er_q = {};
   endtask : settle
   task automatic set_mode(input logic [2:0] bl, input logic il, input logic [1:0] cl);
      @(posedge core_clk);
      mode_burst_len <= bl;
      mode_interleave <= il;
      mode_cas_latency <= cl;
      repeat (4) @(posedge core_clk);
   endtask : set_mode
   initial begin
      logic [31:0] r;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      for (int t = 0; t < 16; t++) begin
         r = xs();
         set_mode({1'b0, r[1:0]}, r[2], 2'h1 + r[4:3] % 2'h3);
         issue(r[15] ? sbce_pkg::CMD_WRITE : sbce_pkg::CMD_READ, r[14:5], blen());
         settle();
      end
      set_mode(sbce_pkg::BL_8, 1'b1, 2'h2);
      // Second command two cycles in: first burst keeps two beats only
      for (int p = 0; p < 3; p++) begin
         issue(p == 2 ? sbce_pkg::CMD_READ : sbce_pkg::CMD_WRITE, 10'h3f5 - 10'(p), 2);
         issue(p == 0 ? sbce_pkg::CMD_WRITE : sbce_pkg::CMD_READ, 10'h012 + 10'(p), 8);
         settle();
      end
      set_mode(sbce_pkg::BL_PAGE, 1'b0, 2'h2);
      issue(sbce_pkg::CMD_READ, 10'h3fe, 2);
      issue(sbce_pkg::CMD_STOP, 10'h000, 0);
      settle();
      set_mode(sbce_pkg::BL_4, 1'b0, 2'h3);
      issue(sbce_pkg::CMD_READ, 10'h00d, 4);
      issue(sbce_pkg::CMD_STOP, 10'h000, 0);
      settle();
      masked = 1'b1;
      ctrl.cmd(sbce_pkg::CMD_READ, 10'h055, 1'b0, 2'h0, 1'b1, 1'b1);
      er_q = {10'h055, 10'h056, 10'h057, 10'h054};
      settle();
      ctrl.cmd(4'h7, 10'h000);
      repeat (6) @(negedge core_clk);
      masked = 1'b0;
      ctrl.cmd(sbce_pkg::CMD_PRE, 10'h000, 1'b1, 2'h0, 1'b1, 1'b0);
      repeat (6) @(negedge core_clk);
      `CHECK(pre_val, 4'hf)
      ctrl.cmd(sbce_pkg::CMD_PRE, 10'h000, 1'b0, 2'h2, 1'b1, 1'b0);
      repeat (6) @(negedge core_clk);
      `CHECK(pre_val, 4'h4)
      // Nothing else issued until the auto-precharge burst is over
      ctrl.cmd(sbce_pkg::CMD_WRITE, 10'h020, 1'b1, 2'h1, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) ew_q.push_back({col_at(10'h020, i), ctrl.word_at(ctrl.wr_cyc + 16'(i))});
      settle();
      `CHECK(pre_val, 4'h2)
      `CHECK(pre_cyc - last_w, int'(sbce_pkg::WR_RECOVERY_CYC))
      @(posedge core_clk);
      bank_active_in <= 4'h0;
      for (int p = 0; p < 2; p++) begin
         ctrl.cmd(p == 0 ? sbce_pkg::CMD_REF : 4'h8, 10'h000, 1'b0, 2'h0, 1'b0, 1'b0);
         ctrl.cmd(sbce_pkg::CMD_READ, 10'h001, 1'b0, 2'h0, 1'b0, 1'b0);
         repeat (4) @(negedge core_clk);
         `CHECK(p == 0 ? self_refresh : power_down, 1'b1)
         ctrl.cmd(4'h7, 10'h000);
         repeat (4 + sbce_pkg::SR_EXIT_CYC) @(negedge core_clk);
         `CHECK({self_refresh, power_down}, 2'h0)
         settle();
      end
      bank_active_in <= 4'hf;
      complete_run();
   end
endmodule : test_sdram_burst_command_engine
`default_nettype wire
